// *** pdol_pkg.sv ***
package pdol_pkg;
  localparam int unsigned CH_FIRST = 3;
  localparam int unsigned CH_COUNT = 6;
  localparam int unsigned LOG_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 8;
  localparam logic [7:0] ADDR_LOG_CH3 = 8'h62;
  localparam logic [7:0] ADDR_LOG_CH4 = 8'h63;
  localparam logic [7:0] ADDR_LOG_CH5 = 8'h64;
  localparam logic [7:0] ADDR_LOG_CH6 = 8'h65;
  localparam logic [7:0] ADDR_LOG_CH7 = 8'h66;
  localparam logic [7:0] ADDR_LOG_CH8 = 8'h67;
  localparam logic [7:0] LOG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int unsigned OFF_THRESHOLD_MV = 200;
  localparam int unsigned SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_POWER_DOWN = 2'b01
  } pdol_seq_type;
endpackage : pdol_pkg

// *** pdol_sync.sv ***
module pdol_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule : pdol_sync

// *** pdol_log_bank.sv ***
module pdol_log_bank
  import pdol_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic active_control_input_i,
  input wire logic [pdol_pkg::CH_COUNT-1:0] below_off_threshold_i,
  input wire logic [pdol_pkg::LOG_WIDTH-1:0] sequence_tag_counter_i,
  input wire logic [pdol_pkg::ADDR_WIDTH-1:0] reg_addr_i,
  output logic [pdol_pkg::LOG_WIDTH-1:0] reg_rdata_o,
  output logic seq_active_o
);
  import pdol_pkg::*;

  logic act_sync;
  logic [CH_COUNT-1:0] below_sync;
  logic act_prev_reg;
  logic [CH_COUNT-1:0] below_prev_reg;
  pdol_seq_type state_reg;
  pdol_seq_type state_next;
  logic [CH_COUNT-1:0] captured_reg;
  logic [CH_COUNT-1:0] captured_next;
  logic [LOG_WIDTH-1:0] log_reg [CH_COUNT];
  logic act_fall;
  logic [CH_COUNT-1:0] cross_fall;
  logic [CH_COUNT-1:0] capture;
  logic addr_hit;
  logic [ADDR_WIDTH-1:0] addr_index;
  logic [LOG_WIDTH-1:0] rdata_next;
  logic [LOG_WIDTH-1:0] rdata_reg;

  // Rails and control come from analog comparators, outside the clock domain
  pdol_sync #(.WIDTH(CH_COUNT + 1)) u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .async_i({active_control_input_i, below_off_threshold_i}),
    .sync_o({act_sync, below_sync})
  );

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      act_prev_reg <= 1'b0;
      below_prev_reg <= '0;
    end else begin
      act_prev_reg <= act_sync;
      below_prev_reg <= below_sync;
    end
  end

  assign act_fall = act_prev_reg & ~act_sync;
  assign cross_fall = below_sync & ~below_prev_reg;

  // A new falling edge restarts the sequence and re-arms every channel
  always_comb begin
    state_next = state_reg;
    captured_next = captured_reg;
    case (state_reg)
      SEQ_IDLE: begin
        if (act_fall) begin
          state_next = SEQ_POWER_DOWN;
          captured_next = '0;
        end
      end
      SEQ_POWER_DOWN: begin
        if (act_fall) begin
          captured_next = '0;
        end else if (act_sync) begin
          state_next = SEQ_IDLE;
        end else begin
          captured_next = captured_reg | capture;
        end
      end
      default: begin
        state_next = SEQ_IDLE;
      end
    endcase
  end

  assign capture = (state_reg == SEQ_POWER_DOWN && !act_sync) ?
                   (cross_fall & ~captured_reg) : '0;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= SEQ_IDLE;
      captured_reg <= '0;
    end else begin
      state_reg <= state_next;
      captured_reg <= captured_next;
    end
  end

  // Full byte is cleared: upper nibble is free to be anything, zero is simplest
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < CH_COUNT; i++) begin
        log_reg[i] <= LOG_RESET;
      end
    end else begin
      for (int i = 0; i < CH_COUNT; i++) begin
        if (capture[i]) begin
          log_reg[i] <= sequence_tag_counter_i;
        end
      end
    end
  end

  // Read-only port: there is no write path, so writes cannot disturb logs
  assign addr_hit = (reg_addr_i >= ADDR_LOG_CH3) && (reg_addr_i <= ADDR_LOG_CH8);
  assign addr_index = reg_addr_i - ADDR_LOG_CH3;
  assign rdata_next = addr_hit ? log_reg[addr_index[2:0]] : UNMAPPED_READ;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg <= LOG_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign seq_active_o = (state_reg == SEQ_POWER_DOWN);
endmodule : pdol_log_bank

// *** pdol_log_bank_monitor.sv ***
module pdol_log_bank_monitor (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic active_control_input_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic seq_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  seq_start_a:
    assert property ($rose(seq_active_o) |-> !$past(active_control_input_i)) else $error("start");
  seq_stop_a:
    assert property ($fell(seq_active_o) |-> $past(active_control_input_i)) else $error("stop");
  unmapped_zero_a:
    assert property (!($past(reg_addr_i) inside {[8'h62:8'h67]}) |-> reg_rdata_o == 8'h00)
      else $error("unmapped");
  reset_nibble_a:
    assert property ($rose(arst_n_i) |-> !reg_rdata_o[3:0] ##1 !reg_rdata_o[3:0]) else $error("reset");
  seq_idle_a:
    assert property ($past(active_control_input_i, 3) |-> !seq_active_o) else $error("idle");
  log_hold_a:
    assert property (!seq_active_o && !$past(seq_active_o) && $stable(reg_addr_i)
      |=> $stable(reg_rdata_o)) else $error("hold");
endmodule : pdol_log_bank_monitor
bind pdol_log_bank pdol_log_bank_monitor i_pdol_log_bank_monitor (.clk_i, .arst_n_i,
  .active_control_input_i, .reg_addr_i, .reg_rdata_o, .seq_active_o);

// *** pdol_log_bank_bench.sv ***
module pdol_log_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pdol_pkg::*;
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
  logic clk = 0, rst_n = 0, ctl = 1, seq;
  logic [5:0] low = 0;
  logic [7:0] tag = 0, addr = 0, rd;
  int miscompares = 0, checks_done = 0;
  always #4 clk = ~clk;
  pdol_log_bank i_pdol_log_bank (.clk_i(clk), .arst_n_i(rst_n), .active_control_input_i(ctl),
    .below_off_threshold_i(low), .sequence_tag_counter_i(tag), .reg_addr_i(addr),
    .reg_rdata_o(rd), .seq_active_o(seq));
  task automatic report_and_stop;
    $display("checks %0d wrong %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // Sweeps one address either side so unmapped reads are covered too
  task automatic rd_all(input bit fresh);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk) addr = ADDR_LOG_CH3 - 8'h01 + 8'(i);
      @(negedge clk) `CHK("log", fresh || i % 7 == 0 ? 8'h00 : 8'ha0 + 8'(i - 1), rd)
    end
  endtask : rd_all
  task automatic power_down;
    ctl = 0;
    repeat (4) @(negedge clk);
    `CHK("seq", 1'b1, seq)
    for (int c = 5; c >= 0; c--) begin
      tag = 8'ha0 + 8'(c);
      low[c] = 1;
      repeat (4) @(negedge clk);
    end
    low[0] = 0;
    repeat (4) @(negedge clk);
    tag = 8'h55;
    low[0] = 1;
    repeat (4) @(negedge clk);
    ctl = 1;
    low = 0;
    repeat (6) @(negedge clk);
    `CHK("seq", 1'b0, seq)
    low = 6'h3f;
    repeat (6) @(negedge clk);
    rd_all(0);
  endtask : power_down
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    rd_all(1);
    power_down;
    rst_n = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    rd_all(1);
    report_and_stop;
  end
  initial begin
    #5us;
    miscompares++;
    report_and_stop;
  end
endmodule : pdol_log_bank_bench
